//--- verilog/lps_cpu_end.sv
`timescale 1ns/100ps
`include "lps_map.svh"
module lps_cpu_end (
    lps_if.cpu                         bus,
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    input  wire logic                  halt_exec,
    input  wire logic                  irq_enable_flag,
    output lps_pkg::lps_state_t        state,
    output logic                       core_clock_run,
    output logic                       pll_run,
    output lps_pkg::lps_events_t       service
);
    import lps_pkg::*;

    lps_state_t  next_state;
    lps_events_t pending;
    lps_events_t raw_events;
    lps_events_t serviceable;
    logic        halted;
    logic        snoop_from_grant;
    logic        smi_prev;
    logic        init_prev;
    logic [1:0]  lint_prev;
    logic        awake;
    logic        stop_req;
    logic        timer_load;
    lps_count_t  timer_value;
    logic        timer_done;
    logic        next_asleep;

    assign stop_req    = !bus.stop_clock_req_n;
    assign awake       = !(state inside {LPS_SLEEP, LPS_DEEP_SLEEP, LPS_DEEP_EXIT});
    assign next_asleep = next_state inside {LPS_SLEEP, LPS_DEEP_SLEEP, LPS_DEEP_EXIT};

    lps_cycle_timer u_timer (
        .clock      (clock),
        .reset_n    (reset_n),
        .load       (timer_load),
        .load_value (timer_value),
        .done       (timer_done)
    );

    // Edge detection of interrupt pins, bus message on snoop answer
    always_comb begin
        raw_events                       = '0;
        raw_events[`LPS_EV_SMI]          = smi_prev && !bus.sys_mgmt_irq_n;
        raw_events[`LPS_EV_INIT]         = init_prev && !bus.soft_init_n;
        raw_events[`LPS_EV_MASKABLE_IRQ] = !lint_prev[`LPS_LINT_MASKABLE_IRQ]
                                           && bus.local_irq_lines[`LPS_LINT_MASKABLE_IRQ];
        raw_events[`LPS_EV_NMI]          = !lint_prev[`LPS_LINT_NMI]
                                           && bus.local_irq_lines[`LPS_LINT_NMI];
        raw_events[`LPS_EV_BUS]          = bus.snoop_ack && bus.snoop_is_irq;
        if (!awake) begin
            raw_events = '0;
        end
    end

    always_comb begin
        serviceable = '0;
        if (state == LPS_NORMAL && bus.cpu_reset_n) begin
            serviceable = pending;
            if (!irq_enable_flag) begin
                serviceable[`LPS_EV_MASKABLE_IRQ] = 1'b0;
            end
        end
    end

    always_comb begin
        next_state  = state;
        timer_load  = 1'b0;
        timer_value = '0;
        case (state)
            LPS_NORMAL: begin
                if (stop_req) begin
                    next_state = LPS_SG_ACK;
                end else if (halt_exec) begin
                    next_state = LPS_AUTO_HALT;
                end
            end
            LPS_AUTO_HALT: begin
                if (stop_req) begin
                    next_state = LPS_SG_ACK;
                end else if (bus.snoop_valid) begin
                    next_state = LPS_SNOOP;
                end else if (|pending) begin
                    next_state = LPS_NORMAL;
                end
            end
            LPS_SG_ACK: begin
                if (bus.sg_response) begin
                    next_state  = LPS_SG_COUNT;
                    timer_load  = 1'b1;
                    timer_value = `LPS_TIMER_W'(`LPS_SG_DELAY_CLKS - 1);
                end
            end
            LPS_SG_COUNT: begin
                if (timer_done) begin
                    next_state = LPS_STOP_GRANT;
                end
            end
            LPS_STOP_GRANT: begin
                if (!stop_req) begin
                    next_state = halted ? LPS_AUTO_HALT : LPS_NORMAL;
                end else if (!bus.sleep_req_n) begin
                    next_state = LPS_SLEEP;
                // snoop state entry, snoops in grant
                end else if (bus.snoop_valid) begin
                    next_state = LPS_SNOOP;
                end
            end
            LPS_SNOOP: begin
                if (bus.snoop_ack || bus.snoop_other_done) begin
                    next_state = snoop_from_grant ? LPS_STOP_GRANT : LPS_AUTO_HALT;
                end
            end
            LPS_SLEEP: begin
                if (!bus.deep_sleep_req_n) begin
                    next_state = LPS_DEEP_SLEEP;
                end else if (bus.sleep_req_n) begin
                    next_state = LPS_STOP_GRANT;
                end
            end
            LPS_DEEP_SLEEP: begin
                if (bus.deep_sleep_req_n) begin
                    next_state  = LPS_DEEP_EXIT;
                    timer_load  = 1'b1;
                    timer_value = `LPS_TIMER_W'(`LPS_PLL_SETTLE_CLKS - 1);
                end
            end
            LPS_DEEP_EXIT: begin
                if (timer_done) begin
                    next_state = LPS_SLEEP;
                end
            end
            default: begin
                next_state = LPS_NORMAL;
            end
        endcase
        // reset keeps grant, sleep resets directly, reset exit
        if (!bus.cpu_reset_n) begin
            next_state = (stop_req && awake) ? LPS_STOP_GRANT : LPS_NORMAL;
            timer_load = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= LPS_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            halted           <= 1'b0;
            snoop_from_grant <= 1'b0;
        end else begin
            if (next_state == LPS_AUTO_HALT) begin
                halted <= 1'b1;
            end else if (next_state == LPS_NORMAL) begin
                halted <= 1'b0;
            end
            if (next_state == LPS_SNOOP && state != LPS_SNOOP) begin
                snoop_from_grant <= (state == LPS_STOP_GRANT);
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            smi_prev  <= 1'b1;
            init_prev <= 1'b1;
            lint_prev <= 2'h0;
        end else begin
            smi_prev  <= bus.sys_mgmt_irq_n;
            init_prev <= bus.soft_init_n;
            lint_prev <= bus.local_irq_lines;
        end
    end

    // latch events, set wins over clear; reset initializes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pending <= '0;
            service <= '0;
        end else if (!bus.cpu_reset_n) begin
            pending <= '0;
            service <= '0;
        end else begin
            pending <= (pending & ~serviceable) | raw_events;
            service <= serviceable;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bus.stop_grant_ack  <= 1'b0;
            bus.snoop_ack       <= 1'b0;
            bus.pending_break_n <= 1'b1;
            core_clock_run      <= 1'b1;
            pll_run             <= 1'b1;
        end else begin
            bus.stop_grant_ack  <= (next_state == LPS_SG_ACK) && (state != LPS_SG_ACK);
            bus.snoop_ack       <= bus.snoop_valid && !bus.snoop_ack && awake
                                   && !bus.snoop_other_done;
            bus.pending_break_n <= !((next_state == LPS_STOP_GRANT) && (|pending));
            core_clock_run      <= !next_asleep;
            pll_run             <= (next_state != LPS_DEEP_SLEEP);
        end
    end
endmodule : lps_cpu_end

//--- verilog/lps_map.svh
// Contract
// - Stop-grant entered 20 clocks after acknowledge response
// - Halt instruction enters auto-halt
// - Auto-halt wakes on management, init, local, bus interrupts
// - Stop-clock during auto-halt returns to halt
// - Auto-halt keeps processing snoops
// - Reset initializes; stop-grant stays stop-grant
// - Stop-clock deassertion leaves stop-grant to Normal, or to auto-halt if entered from auto-halt
// - Stop-clock released ten clocks after sleep release
// - Chipset keeps bus inputs inactive during sleep
// - Snoop or interrupt transaction enters snoop state
// - Serviced snoop returns to originating state
// - Stop-grant latches events, serviced once in Normal
// - Stop-grant processes snoops, latches bus interrupts
// - Pending break asserted for any latched interrupt
// - Chipset answers pending break by leaving low power
// - Sleep entered and requested only from stop-grant
// - Sleep stops core clocks, keeps PLL
// - No snoops or bus changes around sleep
// - Reset in sleep resets directly
// - Chipset releases sleep and stop-clock after reset
// - Deep-sleep request moves sleep to deep sleep
// - Chipset releases sleep before further bus events
// - Deep-sleep exit waits 30 us for PLL
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH

`define LPS_CLOCK_MHZ         100
`define LPS_SG_DELAY_CLKS     20
`define LPS_WAKE_GAP_CLKS     10
`define LPS_PLL_SETTLE_US     30
`define LPS_PLL_SETTLE_CLKS   (`LPS_PLL_SETTLE_US * `LPS_CLOCK_MHZ)
`define LPS_RESET_HOLD_CLKS   16
`define LPS_TIMER_W           12
`define LPS_RESET_CNT_W       5

`define LPS_LINT_MASKABLE_IRQ 0
`define LPS_LINT_NMI          1

`define LPS_EV_SMI            0
`define LPS_EV_INIT           1
`define LPS_EV_MASKABLE_IRQ   2
`define LPS_EV_NMI            3
`define LPS_EV_BUS            4
`define LPS_EV_W              5

`endif

//--- verilog/lps_pkg.sv
`include "lps_map.svh"
package lps_pkg;
    typedef enum logic [3:0] {
        LPS_NORMAL, LPS_AUTO_HALT, LPS_SG_ACK, LPS_SG_COUNT, LPS_STOP_GRANT,
        LPS_SNOOP, LPS_SLEEP, LPS_DEEP_SLEEP, LPS_DEEP_EXIT
    } lps_state_t;

    typedef enum logic [3:0] {
        LPS_H_RUN, LPS_H_WAIT_ACK, LPS_H_COUNT, LPS_H_GRANTED, LPS_H_SLEEP,
        LPS_H_DEEP, LPS_H_DEEP_EXIT, LPS_H_WAKE_GAP
    } lps_host_state_t;

    typedef logic [`LPS_EV_W-1:0]    lps_events_t;
    typedef logic [`LPS_TIMER_W-1:0] lps_count_t;
endpackage : lps_pkg

//--- verilog/lps_if.sv
`timescale 1ns/100ps
interface lps_if;
    logic       stop_clock_req_n;
    logic       sleep_req_n;
    logic       deep_sleep_req_n;
    logic       cpu_reset_n;
    logic       sys_mgmt_irq_n;
    logic       soft_init_n;
    logic [1:0] local_irq_lines;
    logic       sg_response;
    logic       snoop_valid;
    logic       snoop_is_irq;
    logic       snoop_other_done;
    logic       stop_grant_ack;
    logic       snoop_ack;
    logic       pending_break_n;

    modport cpu (
        input  stop_clock_req_n, sleep_req_n, deep_sleep_req_n, cpu_reset_n,
        input  sys_mgmt_irq_n, soft_init_n, local_irq_lines, sg_response,
        input  snoop_valid, snoop_is_irq, snoop_other_done,
        output stop_grant_ack, snoop_ack, pending_break_n
    );

    modport chipset (
        output stop_clock_req_n, sleep_req_n, deep_sleep_req_n, cpu_reset_n,
        output sys_mgmt_irq_n, soft_init_n, local_irq_lines, sg_response,
        output snoop_valid, snoop_is_irq, snoop_other_done,
        input  stop_grant_ack, snoop_ack, pending_break_n
    );
endinterface : lps_if

//--- verilog/lps_cycle_timer.sv
`timescale 1ns/100ps
module lps_cycle_timer (
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic                load,
    input  wire lps_pkg::lps_count_t load_value,
    output logic                     done
);
    import lps_pkg::*;

    lps_count_t count;
    logic       running;

    // Done rises load_value edges after the loading edge
    assign done = running && (count == '0);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count   <= '0;
            running <= 1'b0;
        end else if (load) begin
            count   <= load_value;
            running <= 1'b1;
        end else if (done) begin
            running <= 1'b0;
        end else if (running) begin
            count   <= count - 1'b1;
        end
    end
endmodule : lps_cycle_timer

//--- verilog/lps_chipset_end.sv
`timescale 1ns/100ps
`include "lps_map.svh"
module lps_chipset_end (
    lps_if.chipset                     bus,
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    input  wire logic                  want_low_power,
    input  wire logic                  want_sleep,
    input  wire logic                  want_deep_sleep,
    input  wire logic                  reset_pulse,
    input  wire logic                  snoop_start,
    input  wire logic                  snoop_irq,
    input  wire logic                  snoop_by_other,
    input  wire logic                  irq_smi_n,
    input  wire logic                  irq_init_n,
    input  wire logic [1:0]            irq_lines,
    output lps_pkg::lps_host_state_t   host_state,
    output logic                       snoop_busy
);
    import lps_pkg::*;

    logic                        timer_load;
    lps_count_t                  timer_value;
    logic                        timer_done;
    logic                        sleep_group;
    logic                        snoop_allowed;
    logic [`LPS_RESET_CNT_W-1:0] reset_count;

    assign sleep_group   = host_state inside {LPS_H_SLEEP, LPS_H_DEEP, LPS_H_DEEP_EXIT};
    assign snoop_allowed = host_state inside {LPS_H_RUN, LPS_H_GRANTED};
    assign snoop_busy    = bus.snoop_valid;
    assign timer_load    = ((host_state == LPS_H_WAIT_ACK) && bus.stop_grant_ack)
                           || ((host_state == LPS_H_DEEP) && !want_deep_sleep)
                           || ((host_state == LPS_H_SLEEP) && want_deep_sleep == 1'b0
                               && (!want_sleep || !want_low_power));
    assign timer_value   = (host_state == LPS_H_WAIT_ACK)
                           ? `LPS_TIMER_W'(`LPS_SG_DELAY_CLKS - 1)
                           : (host_state == LPS_H_DEEP)
                           ? `LPS_TIMER_W'(`LPS_PLL_SETTLE_CLKS - 1)
                           : `LPS_TIMER_W'(`LPS_WAKE_GAP_CLKS - 1);

    lps_cycle_timer u_timer (
        .clock      (clock),
        .reset_n    (reset_n),
        .load       (timer_load),
        .load_value (timer_value),
        .done       (timer_done)
    );

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            host_state           <= LPS_H_RUN;
            bus.stop_clock_req_n <= 1'b1;
            bus.sleep_req_n      <= 1'b1;
            bus.deep_sleep_req_n <= 1'b1;
            bus.sg_response      <= 1'b0;
        end else begin
            bus.sg_response <= 1'b0;
            case (host_state)
                LPS_H_RUN: begin
                    if (want_low_power && !reset_pulse) begin
                        bus.stop_clock_req_n <= 1'b0;
                        host_state           <= LPS_H_WAIT_ACK;
                    end
                end
                LPS_H_WAIT_ACK: begin
                    if (bus.stop_grant_ack) begin
                        bus.sg_response <= 1'b1;
                        host_state      <= LPS_H_COUNT;
                    end
                end
                LPS_H_COUNT: begin
                    if (timer_done) begin
                        host_state <= LPS_H_GRANTED;
                    end
                end
                LPS_H_GRANTED: begin
                    if (!bus.pending_break_n || !want_low_power) begin
                        bus.stop_clock_req_n <= 1'b1;
                        host_state           <= LPS_H_RUN;
                    end else if (want_sleep && !bus.snoop_valid && !reset_pulse) begin
                        bus.sleep_req_n <= 1'b0;
                        host_state      <= LPS_H_SLEEP;
                    end
                end
                LPS_H_SLEEP: begin
                    if (want_deep_sleep) begin
                        bus.deep_sleep_req_n <= 1'b0;
                        host_state           <= LPS_H_DEEP;
                    end else if (!want_sleep || !want_low_power) begin
                        bus.sleep_req_n <= 1'b1;
                        host_state      <= LPS_H_WAKE_GAP;
                    end
                end
                LPS_H_DEEP: begin
                    if (!want_deep_sleep) begin
                        bus.deep_sleep_req_n <= 1'b1;
                        host_state           <= LPS_H_DEEP_EXIT;
                    end
                end
                LPS_H_DEEP_EXIT: begin
                    if (timer_done) begin
                        host_state <= LPS_H_SLEEP;
                    end
                end
                LPS_H_WAKE_GAP: begin
                    if (timer_done) begin
                        host_state <= LPS_H_GRANTED;
                    end
                end
                default: begin
                    host_state <= LPS_H_RUN;
                end
            endcase
            // release after reset in sleep; wake gap keeps stop-clock
            if (reset_pulse && sleep_group) begin
                bus.stop_clock_req_n <= 1'b1;
                bus.sleep_req_n      <= 1'b1;
                bus.deep_sleep_req_n <= 1'b1;
                host_state           <= LPS_H_RUN;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reset_count     <= '0;
            bus.cpu_reset_n <= 1'b1;
        end else if (reset_pulse) begin
            reset_count     <= `LPS_RESET_CNT_W'(`LPS_RESET_HOLD_CLKS - 1);
            bus.cpu_reset_n <= 1'b0;
        end else if (reset_count != '0) begin
            reset_count     <= reset_count - 1'b1;
        end else begin
            bus.cpu_reset_n <= 1'b1;
        end
    end

    // snoop lines idle unless a snoop runs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bus.snoop_valid      <= 1'b0;
            bus.snoop_is_irq     <= 1'b0;
            bus.snoop_other_done <= 1'b0;
        end else begin
            bus.snoop_other_done <= bus.snoop_valid && snoop_by_other
                                    && !bus.snoop_other_done && !bus.snoop_ack;
            if (bus.snoop_valid && (bus.snoop_ack || bus.snoop_other_done)) begin
                bus.snoop_valid  <= 1'b0;
                bus.snoop_is_irq <= 1'b0;
            end else if (!bus.snoop_valid && snoop_start && snoop_allowed) begin
                bus.snoop_valid  <= 1'b1;
                bus.snoop_is_irq <= snoop_irq;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bus.sys_mgmt_irq_n  <= 1'b1;
            bus.soft_init_n     <= 1'b1;
            bus.local_irq_lines <= 2'h0;
        end else if (!sleep_group && host_state != LPS_H_WAKE_GAP) begin
            bus.sys_mgmt_irq_n  <= irq_smi_n;
            bus.soft_init_n     <= irq_init_n;
            bus.local_irq_lines <= irq_lines;
        end
    end
endmodule : lps_chipset_end

//--- bench/lps_asserts.sv
`timescale 1ns/100ps
module lps_asserts (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic stop_clock_req_n,
    input wire logic sleep_req_n,
    input wire logic deep_sleep_req_n,
    input wire logic cpu_reset_n,
    input wire logic sg_response,
    input wire logic snoop_valid,
    input wire logic stop_grant_ack,
    input wire logic snoop_ack,
    input wire logic pending_break_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_ack_then_resp:
    assert property (stop_grant_ack |=> !stop_grant_ack && sg_response) else $error("bad ack");
    a_req_gets_ack:
    assert property ($fell(stop_clock_req_n) && cpu_reset_n |-> ##[1:3] stop_grant_ack)
        else $error("no stop ack");
    a_snoop_acked:
    assert property ($rose(snoop_valid) |=> snoop_ack) else $error("snoop not acked");
    a_snoop_closes:
    assert property (snoop_ack |-> snoop_valid ##1 !snoop_valid) else $error("snoop open");
    a_break_granted:
    assert property (!pending_break_n |-> $past(!stop_clock_req_n)) else $error("bad break");
    a_sleep_granted:
    assert property (!sleep_req_n |-> !stop_clock_req_n) else $error("sleep w/o grant");
    a_deep_in_sleep:
    assert property (!deep_sleep_req_n |-> !sleep_req_n) else $error("deep w/o sleep");
    a_no_sleep_snoop:
    assert property (snoop_valid |-> sleep_req_n) else $error("snoop in sleep");
    a_wake_gap_ok:
    assert property ($rose(stop_clock_req_n) && $past(sleep_req_n) |-> $past(sleep_req_n, 10))
        else $error("wake gap short");
    a_reset_hold:
    assert property ($fell(cpu_reset_n) |-> ##15 !cpu_reset_n ##1 cpu_reset_n)
        else $error("reset length");
endmodule : lps_asserts

//--- bench/testbench.sv
`timescale 1ns/100ps
`include "lps_map.svh"
module testbench;
    import lps_pkg::*;
    typedef struct {
        logic        smi_n;
        logic        init_n;
        logic [1:0]  lines;
        logic        msg;
        lps_events_t exp;
    } lps_row_t;
    logic clock = 1'h0, reset_n = 1'h0, halt_exec = 1'h0, irq_enable_flag = 1'h1;
    logic want_low_power = 1'h0, want_sleep = 1'h0, want_deep_sleep = 1'h0;
    logic reset_pulse = 1'h0, snoop_start = 1'h0, snoop_irq = 1'h0, snoop_by_other = 1'h0;
    logic irq_smi_n = 1'h1, irq_init_n = 1'h1;
    logic [1:0] irq_lines = 2'h0;
    lps_state_t state;
    lps_host_state_t host_state;
    lps_events_t service, seen;
    logic core_clock_run, pll_run, snoop_busy;
    int miscompares = 0, n_checks = 0, n;
    lps_row_t rows [5] = '{
        '{1'h0, 1'h1, 2'h0, 1'h0, 5'h01}, '{1'h1, 1'h0, 2'h0, 1'h0, 5'h02},
        '{1'h1, 1'h1, 2'h1, 1'h0, 5'h04}, '{1'h1, 1'h1, 2'h2, 1'h0, 5'h08},
        '{1'h1, 1'h1, 2'h0, 1'h1, 5'h10}};

    lps_if bus ();
    lps_cpu_end u_lps_cpu_end (.bus, .clock, .reset_n, .halt_exec, .irq_enable_flag,
        .state, .core_clock_run, .pll_run, .service);
    lps_chipset_end u_lps_chipset_end (.bus, .clock, .reset_n, .want_low_power,
        .want_sleep, .want_deep_sleep, .reset_pulse, .snoop_start, .snoop_irq,
        .snoop_by_other, .irq_smi_n, .irq_init_n, .irq_lines, .host_state, .snoop_busy);
    lps_asserts u_lps_asserts (.clock, .reset_n, .stop_clock_req_n(bus.stop_clock_req_n),
        .sleep_req_n(bus.sleep_req_n), .deep_sleep_req_n(bus.deep_sleep_req_n),
        .cpu_reset_n(bus.cpu_reset_n), .sg_response(bus.sg_response),
        .snoop_valid(bus.snoop_valid), .stop_grant_ack(bus.stop_grant_ack),
        .snoop_ack(bus.snoop_ack), .pending_break_n(bus.pending_break_n));

    always #5 clock = ~clock;

    task automatic complete_run;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic tmo(input string nm);
        miscompares++;
        $display("ERROR %s expected done seen timeout", nm);
        complete_run();
    endtask : tmo

    task automatic chk_state(input string nm, input lps_state_t exp);
        n_checks++;
        if (state !== exp) begin
            miscompares++;
            $display("ERROR %s expected %s seen %s", nm, exp.name(), state.name());
        end
    endtask : chk_state

    task automatic chk_bits(input string nm, input logic [11:0] exp, input logic [11:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_bits

    task automatic step(input int k);
        repeat (k) begin
            @(posedge clock);
            #1;
            seen |= service;
        end
    endtask : step

    task automatic wait_state(input lps_state_t s);
        n = 0;
        while (state !== s) begin
            step(1);
            n++;
            if (n > 4000) tmo(s.name());
        end
        chk_state("reach", s);
    endtask : wait_state

    function automatic logic pin(input int w);
        return w == 0 ? bus.sg_response : w == 1 ? bus.pending_break_n : bus.cpu_reset_n;
    endfunction : pin

    task automatic wait_pin(input int w, input logic lvl);
        n = 0;
        while (pin(w) !== lvl) begin
            step(1);
            n++;
            if (n > 60) tmo("pin wait");
        end
    endtask : wait_pin

    task automatic pulse_halt;
        @(posedge clock) halt_exec <= 1'h1;
        @(posedge clock) halt_exec <= 1'h0;
        wait_state(LPS_AUTO_HALT);
    endtask : pulse_halt

    task automatic bus_reset;
        @(posedge clock) reset_pulse <= 1'h1;
        @(posedge clock) reset_pulse <= 1'h0;
        step(2);
        wait_pin(2, 1'h1);
    endtask : bus_reset

    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'h1;
        #1;
        chk_state("reset", LPS_NORMAL);
        // Each wake source out of auto-halt
        foreach (rows[i]) begin
            pulse_halt();
            @(posedge clock) begin
                irq_smi_n <= rows[i].smi_n;
                irq_init_n <= rows[i].init_n;
                irq_lines <= rows[i].lines;
                snoop_start <= rows[i].msg;
                snoop_irq <= rows[i].msg;
            end
            @(posedge clock) snoop_start <= 1'h0;
            seen = '0;
            step(14);
            chk_state("wake", LPS_NORMAL);
            chk_bits("service", 12'(rows[i].exp), 12'(seen));
            @(posedge clock) begin
                irq_smi_n <= 1'h1;
                irq_init_n <= 1'h1;
                irq_lines <= 2'h0;
            end
        end
        pulse_halt();
        @(posedge clock) begin
            snoop_by_other <= 1'h1;
            snoop_start <= 1'h1;
            snoop_irq <= 1'h0;
        end
        @(posedge clock) snoop_start <= 1'h0;
        wait_state(LPS_SNOOP);
        wait_state(LPS_AUTO_HALT);
        @(posedge clock) want_low_power <= 1'h1;
        wait_pin(0, 1'h1);
        // Count from the edge that samples the response
        step(1);
        wait_state(LPS_STOP_GRANT);
        chk_bits("grant delay", 12'h014, 12'(n));
        @(posedge clock) want_low_power <= 1'h0;
        step(6);
        chk_state("resume", LPS_AUTO_HALT);
        @(posedge clock) irq_lines <= 2'h2;
        wait_state(LPS_NORMAL);
        @(posedge clock) begin
            irq_lines <= 2'h0;
            irq_enable_flag <= 1'h0;
            want_low_power <= 1'h1;
        end
        wait_state(LPS_STOP_GRANT);
        @(posedge clock) irq_lines <= 2'h1;
        wait_pin(1, 1'h0);
        chk_state("break", LPS_STOP_GRANT);
        @(posedge clock) want_low_power <= 1'h0;
        wait_state(LPS_NORMAL);
        seen = '0;
        step(8);
        chk_bits("masked", 12'h000, 12'(seen));
        @(posedge clock) irq_enable_flag <= 1'h1;
        step(8);
        chk_bits("unmasked", 12'h004, 12'(seen));
        @(posedge clock) begin
            irq_lines <= 2'h0;
            want_low_power <= 1'h1;
        end
        wait_state(LPS_STOP_GRANT);
        @(posedge clock) want_sleep <= 1'h1;
        wait_state(LPS_SLEEP);
        chk_bits("clocks", 12'h001, 12'({core_clock_run, pll_run}));
        @(posedge clock) want_deep_sleep <= 1'h1;
        wait_state(LPS_DEEP_SLEEP);
        @(posedge clock) want_deep_sleep <= 1'h0;
        wait_state(LPS_DEEP_EXIT);
        wait_state(LPS_SLEEP);
        chk_bits("settle", 12'(`LPS_PLL_SETTLE_CLKS), 12'(n));
        @(posedge clock) want_sleep <= 1'h0;
        wait_state(LPS_STOP_GRANT);
        bus_reset();
        chk_state("grant reset", LPS_STOP_GRANT);
        @(posedge clock) want_sleep <= 1'h1;
        wait_state(LPS_SLEEP);
        // Reset lands while still asleep, requests drop with it
        fork
            bus_reset();
            @(posedge clock) begin
                want_sleep <= 1'h0;
                want_low_power <= 1'h0;
            end
        join
        chk_state("sleep reset", LPS_NORMAL);
        chk_bits("host", 12'(LPS_H_RUN), 12'(host_state));
        pulse_halt();
        @(posedge clock) reset_n <= 1'h0;
        step(1);
        chk_state("mid reset", LPS_NORMAL);
        @(posedge clock) reset_n <= 1'h1;
        step(2);
        chk_state("reset exit", LPS_NORMAL);
        complete_run();
    end
endmodule : testbench
